/* bench/board_mem_model.sv */
`default_nettype none
// station prom, boot rom and sram on the private data bus
module board_mem_model (
    input wire logic clk_in,
    input wire logic prom_sel_n_in,
    input wire logic boot_sel_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [9:0] addr_in,
    input wire logic [7:0] bus_in,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:1023];
    logic [7:0] last = 8'h00;
    initial begin
        for (int i = 0; i < 1024; i++) begin
            mem[i] = i[7:0] ^ 8'h33;
        end
    end
    // a released bus shows the inverse of the last value
    always_comb begin
        if (prom_sel_n_in === 1'b0) begin
            data_out = {4'ha, addr_in[3:0]};
        end else if (boot_sel_n_in === 1'b0) begin
            data_out = addr_in[7:0] ^ 8'h22;
        end else if (oe_n_in === 1'b0) begin
            data_out = mem[addr_in];
        end else begin
            data_out = ~last;
        end
    end
    // remember only what a device really drove
    always @(posedge clk_in) begin
        if (!(prom_sel_n_in && boot_sel_n_in && oe_n_in)) begin
            last <= data_out;
        end
    end
    // the sram latches at the end of its write strobe
    always @(posedge we_n_in) begin
        mem[addr_in] <= bus_in;
    end
endmodule // board_mem_model
`default_nettype wire

/* bench/shared_memory_isa_board_interface_bench.sv */
`default_nettype none
module shared_memory_isa_board_interface_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 0, rst_n_in = 0, sleep_n = 1, cs16_drv = 0;
    logic bm_n = 1, sm_n = 1, psel_in = 1, frej = 0, sact = 0;
    logic [1:0] map = 2'b00;
    shmem_pkg::isa_cmd_s isa = '{1, 1, 1, 1, 0, 1, 16'h0000};
    logic [15:0] sd_drv = 16'h0000;
    logic psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, rdy, cs16_out, cs16_oe, s_hit;
    logic abe_n, st_n, bt_n, roe_n, rwe_n, ld_oe, xd, fr, so_oe, wstb;
    logic [15:0] sd_out, sd_oe, s_sd, s_oe;
    logic [9:0] la;
    logic [7:0] ld_out, ld_mem, wd, got_wd;
    logic [3:0] wa, got_wa, ind, led_c = 4'h0;
    logic [5:0] s_sel;
    int n_mismatch = 0, compares = 0;
    wire logic [15:0] sd_w = (sd_oe & sd_out) | (~sd_oe & sd_drv);
    wire logic [7:0] ld_w = ld_oe ? ld_out : ld_mem;
    wire logic cs16_w = cs16_oe ? cs16_out : cs16_drv;

    always #10 clk_in = ~clk_in;

    shmem_board_iface u_dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .sleep_n_in(sleep_n),
        .arch_select_n_in(1'b0), .isa_in(isa), .sd_in(sd_w),
        .sd_out(sd_out), .sd_oe_out(sd_oe), .iochrdy_out(rdy),
        .iocs16_in(cs16_w), .iocs16_out(cs16_out),
        .iocs16_oe_out(cs16_oe), .io_base_map_in(map),
        .boot_rom_match_n_in(bm_n), .shmem_match_n_in(sm_n),
        .addr_buf_enable_n_out(abe_n), .station_prom_select_n_out(st_n),
        .boot_rom_select_n_out(bt_n), .ram_out_enable_n_out(roe_n),
        .ram_write_enable_n_out(rwe_n), .local_addr_bus_out(la),
        .local_addr_bus_oe_out(), .local_data_bus_in(ld_w),
        .local_data_bus_out(ld_out), .local_data_bus_oe_out(ld_oe),
        .xcvr_disable_out(xd), .port_select_in(psel_in),
        .filter_reject_in(frej), .frame_reject_out(fr),
        .led_cond_in(led_c), .frame_start_delim_in(1'b0),
        .serial_rx_data_in(1'b0), .serial_rx_clk_in(1'b0),
        .indicator_n_out(ind), .scan_active_in(sact),
        .scan_data_in(1'b0), .scan_data_out(), .scan_data_oe_out(so_oe),
        .io_wr_data_out(wd), .io_wr_addr_out(wa), .io_wr_strobe_out(wstb),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr)
    );

    board_mem_model u_mem (
        .clk_in(clk_in), .prom_sel_n_in(st_n), .boot_sel_n_in(bt_n),
        .oe_n_in(roe_n), .we_n_in(rwe_n), .addr_in(la), .bus_in(ld_w),
        .data_out(ld_mem)
    );

    always @(posedge clk_in) begin
        if (wstb === 1'b1) begin
            got_wd <= wd;
            got_wa <= wa;
        end
    end

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge clk_in);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_in);
        penable <= 1;
        do @(posedge clk_in); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    // k: 0 io read, 1 io write, 2 mem read, 3 mem write; mt: 1 boot, 2 ram
    task automatic isa_go(input int k, input int mt, input logic aen,
            input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_in);
        isa.sa <= a;
        isa.aen <= aen;
        sd_drv <= d;
        {isa.ior_n, isa.iow_n, isa.memr_n, isa.memw_n} <= ~(4'h8 >> k);
        bm_n <= (mt != 1);
        sm_n <= (mt != 2);
        for (int i = 0; i < 8 && rdy !== 1'b0; i++) @(posedge clk_in);
        s_hit = (rdy === 1'b0);
        for (int i = 0; i < 40 && rdy !== 1'b1; i++) @(posedge clk_in);
        s_sd = sd_out;
        s_oe = sd_oe;
        s_sel = {abe_n, st_n, bt_n, roe_n, rwe_n, cs16_oe};
        {isa.ior_n, isa.iow_n, isa.memr_n, isa.memw_n} <= 4'hf;
        bm_n <= 1;
        sm_n <= 1;
        repeat (3) @(posedge clk_in);
    endtask

    // {ctrl port bits, pin, expected transceiver disable}
    logic [3:0] port_tab [5] = '{4'h9, 4'h2, 4'h4, 4'h7, 4'hc};

    initial begin
        repeat (2) @(posedge clk_in);
        chk({rdy, xd, abe_n, st_n, bt_n, roe_n, rwe_n, ind, sd_oe},
            27'h7ff_0000);
        rst_n_in <= 1;
        repeat (2) @(posedge clk_in);
        apb(0, shmem_pkg::CTRL_OFF, 0);
        chk({err, rd}, {1'b0, shmem_pkg::CTRL_RESET});
        apb(0, shmem_pkg::LEDSEL_OFF, 0);
        chk({err, rd}, {1'b0, shmem_pkg::LEDSEL_RESET});
        apb(0, 8'h40, 0);
        chk(err, 1);
        apb(1, shmem_pkg::LEDSEL_OFF, 32'h0000_0007);
        led_c <= 4'h5;
        for (int t = 0; t < 5; t++) begin
            apb(1, shmem_pkg::CTRL_OFF, {30'h0, port_tab[t][3:2]});
            psel_in <= port_tab[t][1];
            repeat (3) @(posedge clk_in);
            chk(xd, port_tab[t][0]);
        end
        chk(ind, 4'ha);
        apb(1, shmem_pkg::CTRL_OFF, 32'h0000_0004);
        for (int i = 0; i < 4; i++) begin
            frej <= i[0];
            psel_in <= i[1];
            repeat (3) @(posedge clk_in);
            chk(fr, i[0] | i[1]);
        end
        chk(ind, 4'h0);
        apb(1, shmem_pkg::CTRL_OFF, 0);
        // mid-run reset held for the minimum the host must give
        rst_n_in <= 0;
        repeat (shmem_pkg::RESET_MIN_XTAL_PERIODS) @(posedge clk_in);
        rst_n_in <= 1;
        repeat (2) @(posedge clk_in);
        apb(0, shmem_pkg::LEDSEL_OFF, 0);
        chk(rd, shmem_pkg::LEDSEL_RESET);
        for (int m = 0; m < 4; m++) begin
            logic [15:0] b;
            b = 16'h0300 + 16'(m * 32);
            map <= m[1:0];
            isa_go(0, 0, 0, b + 16'h0003, 0);
            chk({s_hit, s_sel[4:0], s_oe, s_sd[7:0]},
                {6'b101110, 16'h00ff, 8'ha3});
            isa_go(0, 0, 0, b ^ 16'h0080, 0);
            chk({s_hit, s_oe}, 0);
            isa_go(0, 0, 1, b + 16'h0003, 0);
            chk({s_hit, s_oe}, 0);
        end
        // register reads are not served here; only the iocs16 claim shows
        isa_go(0, 0, 0, 16'h0370, 0);
        chk({s_hit, s_sel[0]}, 2'b00);
        cs16_drv <= 1;
        isa_go(0, 0, 0, 16'h0370, 0);
        chk({s_hit, s_sel[0]}, 2'b01);
        isa_go(1, 0, 0, 16'h0372, 16'h005c);
        chk({s_hit, got_wa, got_wd}, 13'h025c | 13'h1000);
        isa_go(3, 2, 0, 16'h0105, 16'h00c7);
        chk({s_hit, u_mem.mem[10'h105]}, 9'h1c7);
        isa_go(2, 2, 0, 16'h0105, 0);
        chk({s_sel, s_oe, s_sd[7:0]}, {6'b011010, 16'h00ff, 8'hc7});
        isa.sbhe_n <= 0;
        repeat (3) @(posedge clk_in);
        isa_go(2, 2, 0, 16'h0104, 0);
        chk({s_oe, s_sd}, 32'hffff_c737);
        isa_go(2, 1, 0, 16'h0006, 0);
        chk({s_sel, s_sd}, {6'b010110, 16'h2524});
        isa.sbhe_n <= 1;
        apb(1, shmem_pkg::LEDSEL_OFF, 32'h0000_0007);
        sleep_n <= 0;
        repeat (3) @(posedge clk_in);
        chk({xd, ind}, 5'h1f);
        isa_go(0, 0, 0, 16'h0363, 0);
        chk({s_hit, s_oe}, 0);
        sleep_n <= 1;
        repeat (3) @(posedge clk_in);
        apb(0, shmem_pkg::LEDSEL_OFF, 0);
        chk(rd, shmem_pkg::LEDSEL_RESET);
        sact <= 1;
        repeat (2) @(posedge clk_in);
        chk(so_oe, 1);
        sact <= 0;
        repeat (2) @(posedge clk_in);
        chk(so_oe, 0);
        give_verdict();
    end

    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule // shared_memory_isa_board_interface_bench
`default_nettype wire

/* rtl/edge_seen.sv */
`default_nettype none
// sticky flag set once the chosen edge has been seen on a line
module edge_seen #(
    parameter bit RISING = 1'b0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    input wire logic line_in,
    output logic seen_out
);
    logic last_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            last_q <= !RISING;
            seen_out <= 1'b0;
        end else begin
            last_q <= line_in;
            if (clear_in) begin
                seen_out <= 1'b0;
            end else if (RISING ? (line_in && !last_q)
                                : (!line_in && last_q)) begin
                seen_out <= 1'b1;
            end
        end
    end
endmodule // edge_seen
`default_nettype wire

/* rtl/shmem_board_iface.sv */
// Our own choices: the address map and the APB slave port.
`default_nettype none
// Operation
// [R1] host holds reset ten clock periods
// [R2] reset drives outputs to defined idle
// [R3] 8-bit only until sbhe falls once
// [R4] drive data on read, capture on write
// [R5] buffer enable low copies upper address
// [R6] low 16 io bytes read station prom
// [R7] boot match with memr selects boot rom
// [R8] transceiver disable high for twisted pair/sleep
// [R9] io base chosen by two map inputs
// [R10] indicators active low, software selected
// [R11] ext address mode repurposes indicators
// [R12] port select pin used when enabled
// [R13] reject when filter or reject pin
// [R14] sleep resets and ignores inputs
// [R15] host waits before starting after wake
// [R16] arch select sampled after reset
// [R17] shared match drives ram strobes
// [R18] board supplies timing source
// [R19] scan output high-z when idle
// [R20] io valid only aen low and match
// [R21] ready high once data valid
// [R22] io 16-bit only after iocs16 high
// [R23] outside window ignored, data high-z
// [R24] 16-bit memory read as two bytes
module shmem_board_iface (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sleep_n_in,
    input wire logic arch_select_n_in,
    input wire shmem_pkg::isa_cmd_s isa_in,
    input wire logic [15:0] sd_in,
    output logic [15:0] sd_out,
    output logic [15:0] sd_oe_out,
    output logic iochrdy_out,
    input wire logic iocs16_in,
    output logic iocs16_out,
    output logic iocs16_oe_out,
    input wire logic [1:0] io_base_map_in,
    input wire logic boot_rom_match_n_in,
    input wire logic shmem_match_n_in,
    output logic addr_buf_enable_n_out,
    output logic station_prom_select_n_out,
    output logic boot_rom_select_n_out,
    output logic ram_out_enable_n_out,
    output logic ram_write_enable_n_out,
    output logic [9:0] local_addr_bus_out,
    output logic local_addr_bus_oe_out,
    input wire logic [7:0] local_data_bus_in,
    output logic [7:0] local_data_bus_out,
    output logic local_data_bus_oe_out,
    output logic xcvr_disable_out,
    input wire logic port_select_in,
    input wire logic filter_reject_in,
    output logic frame_reject_out,
    input wire logic [3:0] led_cond_in,
    input wire logic frame_start_delim_in,
    input wire logic serial_rx_data_in,
    input wire logic serial_rx_clk_in,
    output logic [3:0] indicator_n_out,
    input wire logic scan_active_in,
    input wire logic scan_data_in,
    output logic scan_data_out,
    output logic scan_data_oe_out,
    output logic [7:0] io_wr_data_out,
    output logic [3:0] io_wr_addr_out,
    output logic io_wr_strobe_out,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    ////////////////////////////////////////////////////////////////////////
    // reset and sleep: sleep is an internal reset
    logic int_rst;
    logic arch_q;
    logic arch_taken_q;
    logic shared_mode;
    logic sbhe_seen;
    logic iocs16_seen;
    assign int_rst = !sleep_n_in; // [R14]
    assign shared_mode = arch_taken_q && !arch_q;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arch_q <= 1'b1;
            arch_taken_q <= 1'b0;
        end else if (!arch_taken_q) begin
            arch_q <= arch_select_n_in; // [R16]
            arch_taken_q <= 1'b1;
        end
    end

    edge_seen #(.RISING(1'b0)) u_sbhe (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(int_rst),
        .line_in(isa_in.sbhe_n),
        .seen_out(sbhe_seen)
    ); // [R3]

    edge_seen #(.RISING(1'b1)) u_iocs16 (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(int_rst),
        .line_in(iocs16_in),
        .seen_out(iocs16_seen)
    ); // [R22]

    ////////////////////////////////////////////////////////////////////////
    // apb registers
    logic [31:0] ctrl_q;
    logic [31:0] ledsel_q;
    logic apb_wr;
    assign apb_wr = psel && penable && pwrite;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= shmem_pkg::CTRL_RESET;
            ledsel_q <= shmem_pkg::LEDSEL_RESET;
        end else if (int_rst) begin
            ctrl_q <= shmem_pkg::CTRL_RESET;
            ledsel_q <= shmem_pkg::LEDSEL_RESET;
        end else if (apb_wr) begin
            if (paddr == shmem_pkg::CTRL_OFF) begin
                ctrl_q <= {29'h0, pwdata[2:0]};
            end else if (paddr == shmem_pkg::LEDSEL_OFF) begin
                ledsel_q <= {24'h0, pwdata[7:0]};
            end
        end
    end

    logic [31:0] status_word;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (paddr == shmem_pkg::CTRL_OFF) begin
                    prdata <= ctrl_q;
                end else if (paddr == shmem_pkg::STATUS_OFF) begin
                    prdata <= status_word;
                end else if (paddr == shmem_pkg::LEDSEL_OFF) begin
                    prdata <= ledsel_q;
                end else begin
                    pslverr <= 1'b1;
                end
            end else if (psel && !penable) begin
                pslverr <= (paddr != shmem_pkg::CTRL_OFF) &&
                           (paddr != shmem_pkg::LEDSEL_OFF);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // io decode
    logic [9:0] io_base;
    logic io_hit;
    logic prom_hit;
    always_comb begin
        if (io_base_map_in == 2'b00) begin // [R9]
            io_base = shmem_pkg::IO_BASE_0;
        end else if (io_base_map_in == 2'b01) begin
            io_base = shmem_pkg::IO_BASE_1;
        end else if (io_base_map_in == 2'b10) begin
            io_base = shmem_pkg::IO_BASE_2;
        end else begin
            io_base = shmem_pkg::IO_BASE_3;
        end
    end
    // window is 32 bytes; sa0 selects byte within word
    assign io_hit = !isa_in.aen &&
        (isa_in.sa[9:5] == io_base[9:5]) && shared_mode; // [R20] [R23]
    assign prom_hit = io_hit && (isa_in.sa[4] == 1'b0); // [R6]

    ////////////////////////////////////////////////////////////////////////
    // cycle sequencer
    shmem_pkg::cyc_state_e state_q;
    logic [7:0] wait_q;
    logic [7:0] lo_byte_q;
    logic wide_q;
    logic is_boot_q;
    logic is_ram_q;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic cmd_active;
    assign mem_rd = !isa_in.memr_n &&
        (!boot_rom_match_n_in || !shmem_match_n_in); // [R7] [R17]
    assign mem_wr = !isa_in.memw_n && !shmem_match_n_in; // [R17]
    assign io_rd = !isa_in.ior_n && io_hit;
    assign io_wr = !isa_in.iow_n && io_hit;
    assign cmd_active = !isa_in.ior_n || !isa_in.iow_n ||
        !isa_in.memr_n || !isa_in.memw_n;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin // [R2]
            state_q <= shmem_pkg::ST_IDLE;
            wait_q <= 8'h00;
            lo_byte_q <= 8'h00;
            wide_q <= 1'b0;
            is_boot_q <= 1'b0;
            is_ram_q <= 1'b0;
            sd_out <= 16'h0000;
            sd_oe_out <= 16'h0000;
            iochrdy_out <= 1'b1;
            iocs16_out <= 1'b0;
            iocs16_oe_out <= 1'b0;
            addr_buf_enable_n_out <= 1'b1;
            station_prom_select_n_out <= 1'b1;
            boot_rom_select_n_out <= 1'b1;
            ram_out_enable_n_out <= 1'b1;
            ram_write_enable_n_out <= 1'b1;
            local_addr_bus_out <= 10'h000;
            local_addr_bus_oe_out <= 1'b0;
            local_data_bus_out <= 8'h00;
            local_data_bus_oe_out <= 1'b0;
            io_wr_data_out <= 8'h00;
            io_wr_addr_out <= 4'h0;
            io_wr_strobe_out <= 1'b0;
        end else if (int_rst) begin // [R14]
            state_q <= shmem_pkg::ST_IDLE;
            sd_oe_out <= 16'h0000;
            iochrdy_out <= 1'b1;
            iocs16_oe_out <= 1'b0;
            addr_buf_enable_n_out <= 1'b1;
            station_prom_select_n_out <= 1'b1;
            boot_rom_select_n_out <= 1'b1;
            ram_out_enable_n_out <= 1'b1;
            ram_write_enable_n_out <= 1'b1;
            local_addr_bus_oe_out <= 1'b0;
            local_data_bus_oe_out <= 1'b0;
            io_wr_strobe_out <= 1'b0;
        end else begin
            io_wr_strobe_out <= 1'b0;
            // 16-bit io claim for register space only
            iocs16_oe_out <= io_hit && !prom_hit && iocs16_seen; // [R22]
            iocs16_out <= 1'b0;
            case (state_q)
                shmem_pkg::ST_IDLE: begin
                    wait_q <= 8'h00;
                    wide_q <= sbhe_seen && !isa_in.sbhe_n &&
                        !isa_in.sa[0]; // [R3]
                    is_boot_q <= !boot_rom_match_n_in;
                    is_ram_q <= !shmem_match_n_in;
                    local_addr_bus_out <= isa_in.sa[9:0];
                    if (mem_rd || (io_rd && prom_hit)) begin
                        iochrdy_out <= 1'b0;
                        local_addr_bus_oe_out <= 1'b1;
                        addr_buf_enable_n_out <= 1'b0; // [R5]
                        station_prom_select_n_out <= !io_rd; // [R6]
                        boot_rom_select_n_out <=
                            !(mem_rd && !boot_rom_match_n_in); // [R7]
                        ram_out_enable_n_out <=
                            !(mem_rd && boot_rom_match_n_in); // [R17]
                        state_q <= shmem_pkg::ST_LO;
                    end else if (mem_wr || io_wr) begin
                        iochrdy_out <= 1'b0;
                        local_addr_bus_oe_out <= mem_wr;
                        addr_buf_enable_n_out <= !mem_wr; // [R5]
                        state_q <= shmem_pkg::ST_WR;
                    end
                end
                shmem_pkg::ST_LO: begin
                    wait_q <= wait_q + 8'h01;
                    if (wait_q == 8'(shmem_pkg::PRIV_ACCESS_CYC - 1)) begin
                        wait_q <= 8'h00;
                        lo_byte_q <= local_data_bus_in;
                        if (wide_q && !io_rd) begin // [R24]
                            local_addr_bus_out[0] <= 1'b1;
                            state_q <= shmem_pkg::ST_HI;
                        end else begin
                            sd_out <= {8'h00, local_data_bus_in}; // [R4]
                            sd_oe_out <= 16'h00ff;
                            iochrdy_out <= 1'b1; // [R21]
                            state_q <= shmem_pkg::ST_DONE;
                        end
                    end
                end
                shmem_pkg::ST_HI: begin
                    wait_q <= wait_q + 8'h01;
                    if (wait_q == 8'(shmem_pkg::PRIV_ACCESS_CYC - 1)) begin
                        sd_out <= {local_data_bus_in, lo_byte_q}; // [R24]
                        sd_oe_out <= 16'hffff; // [R4]
                        iochrdy_out <= 1'b1; // [R21]
                        state_q <= shmem_pkg::ST_DONE;
                    end
                end
                shmem_pkg::ST_WR: begin
                    wait_q <= wait_q + 8'h01;
                    local_data_bus_out <= sd_in[7:0]; // [R4]
                    local_data_bus_oe_out <= is_ram_q;
                    ram_write_enable_n_out <= !is_ram_q; // [R17]
                    if (wait_q == 8'(shmem_pkg::PRIV_ACCESS_CYC - 1)) begin
                        io_wr_data_out <= sd_in[7:0];
                        io_wr_addr_out <= isa_in.sa[3:0];
                        io_wr_strobe_out <= !is_ram_q;
                        ram_write_enable_n_out <= 1'b1;
                        iochrdy_out <= 1'b1; // [R21]
                        state_q <= shmem_pkg::ST_DONE;
                    end
                end
                default: begin
                    if (!cmd_active) begin
                        sd_oe_out <= 16'h0000; // [R23]
                        station_prom_select_n_out <= 1'b1;
                        boot_rom_select_n_out <= 1'b1;
                        ram_out_enable_n_out <= 1'b1;
                        addr_buf_enable_n_out <= 1'b1;
                        local_addr_bus_oe_out <= 1'b0;
                        local_data_bus_oe_out <= 1'b0;
                        state_q <= shmem_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // network side pins
    logic tp_sel;
    logic ext_addr_iface_mode;
    assign ext_addr_iface_mode = ctrl_q[shmem_pkg::CTRL_EXT_ADDR_IFACE_MODE_BIT];
    assign tp_sel = (ctrl_q[shmem_pkg::CTRL_EXT_PORT_EN_BIT] && !ext_addr_iface_mode) ?
        port_select_in : ctrl_q[shmem_pkg::CTRL_SW_TP_BIT]; // [R12]
    assign status_word = {24'h0, sbhe_seen, iocs16_seen, shared_mode,
        tp_sel, int_rst, state_q};

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            xcvr_disable_out <= 1'b1;
            frame_reject_out <= 1'b0;
            indicator_n_out <= 4'hf;
            scan_data_out <= 1'b0;
            scan_data_oe_out <= 1'b0;
        end else begin
            xcvr_disable_out <= tp_sel || int_rst; // [R8]
            frame_reject_out <= !int_rst && (filter_reject_in ||
                (ext_addr_iface_mode && port_select_in)); // [R13]
            scan_data_oe_out <= scan_active_in; // [R19]
            scan_data_out <= scan_data_in;
            if (int_rst) begin
                indicator_n_out <= 4'hf;
            end else if (ext_addr_iface_mode) begin // [R11]
                indicator_n_out <= {serial_rx_clk_in, serial_rx_data_in,
                    frame_start_delim_in,
                    !(led_cond_in[0] && ledsel_q[0])};
            end else begin
                indicator_n_out <= ~(led_cond_in & ledsel_q[3:0]); // [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    a_ready_low_cycle: assert property ( // [R21]
        @(posedge clk_in) disable iff (!rst_n_in || int_rst)
        (state_q == shmem_pkg::ST_IDLE && io_rd && prom_hit) |=>
            !iochrdy_out ##[1:8] iochrdy_out && sd_oe_out == 16'h00ff)
        else $error("ready or data not in time");
    a_xcvr_follows: assert property ( // [R8]
        @(posedge clk_in) disable iff (!rst_n_in)
        int_rst |=> xcvr_disable_out)
        else $error("transceiver not disabled in sleep");
    a_sleep_quiet: assert property ( // [R14]
        @(posedge clk_in) disable iff (!rst_n_in)
        $past(int_rst) |-> sd_oe_out == 16'h0000 && ram_write_enable_n_out)
        else $error("outputs active in sleep");
    a_prom_no_cs16: assert property ( // [R6]
        @(posedge clk_in) disable iff (!rst_n_in)
        !station_prom_select_n_out |-> !iocs16_oe_out)
        else $error("iocs16 during prom read");
    a_narrow_before: assert property ( // [R3]
        @(posedge clk_in) disable iff (!rst_n_in)
        !sbhe_seen && state_q == shmem_pkg::ST_LO |=> state_q !=
            shmem_pkg::ST_HI)
        else $error("wide cycle before sbhe edge");
    a_cs16_gate: assert property ( // [R22]
        @(posedge clk_in) disable iff (!rst_n_in)
        iocs16_oe_out |-> $past(iocs16_seen))
        else $error("16-bit io before iocs16 high");
    a_outside_quiet: assert property ( // [R23]
        @(posedge clk_in) disable iff (!rst_n_in)
        state_q == shmem_pkg::ST_IDLE && !mem_rd && !mem_wr && !io_hit
            |=> state_q == shmem_pkg::ST_IDLE)
        else $error("foreign cycle claimed");
    a_boot_select: assert property ( // [R7]
        @(posedge clk_in) disable iff (!rst_n_in || int_rst)
        state_q == shmem_pkg::ST_IDLE && mem_rd && !boot_rom_match_n_in
            |=> !boot_rom_select_n_out && ram_out_enable_n_out)
        else $error("boot rom not selected");
endmodule // shmem_board_iface
`default_nettype wire

/* rtl/shmem_pkg.sv */
`default_nettype none
package shmem_pkg;
    // apb register map
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] LEDSEL_OFF = 8'h08;
    // ctrl fields
    localparam int CTRL_EXT_PORT_EN_BIT = 0;
    localparam int CTRL_SW_TP_BIT = 1;
    localparam int CTRL_EXT_ADDR_IFACE_MODE_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] LEDSEL_RESET = 32'h0000_0000;
    // io window
    localparam logic [9:0] IO_BASE_0 = 10'h300;
    localparam logic [9:0] IO_BASE_1 = 10'h320;
    localparam logic [9:0] IO_BASE_2 = 10'h340;
    localparam logic [9:0] IO_BASE_3 = 10'h360;
    localparam int PROM_WINDOW_BYTES = 16;
    localparam int ADDR_BUF_STAGES = 6;
    // timing
    localparam int CLK_MHZ = 50;
    localparam int PRIV_ACCESS_NS = 100;
    localparam int PRIV_ACCESS_CYC =
        (PRIV_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_MIN_XTAL_PERIODS = 10;

    typedef enum logic [2:0] {
        ST_IDLE, ST_LO, ST_HI, ST_WR, ST_DONE
    } cyc_state_e;

    typedef struct packed {
        logic ior_n;
        logic iow_n;
        logic memr_n;
        logic memw_n;
        logic aen;
        logic sbhe_n;
        logic [15:0] sa;
    } isa_cmd_s;
endpackage
`default_nettype wire
